// ### design/swk_mode_pkg.sv
// package: register map, mode codes, flag positions and timing for the selective-wake block
package swk_mode_pkg;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STAT = 4'h4;
	localparam logic [3:0] ADDR_CLR = 4'h8;
	localparam logic [3:0] ADDR_EFF = 4'hc;

	// ctrl fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_MASK_BIT = 4;
	localparam int CTRL_CFG_BIT = 5;
	localparam int CTRL_DEV_LSB = 8;

	// status / clear bit positions
	localparam int ST_TIMEOUT = 0;
	localparam int ST_SILENCE = 1;
	localparam int ST_SYNC = 2;
	localparam int ST_ARMED = 3;
	localparam int ST_SYSTEM_ERROR_BIT = 4;
	localparam int ST_CNT_LSB = 8;

	// ****************************************
	// mode codes
	// ****************************************
	localparam logic [2:0] MODE_OFF = 3'h0;
	localparam logic [2:0] MODE_WAKE = 3'h1;
	localparam logic [2:0] MODE_RXONLY = 3'h2;
	localparam logic [2:0] MODE_NORMAL = 3'h3;
	localparam logic [2:0] MODE_OFF2 = 3'h4;
	localparam logic [2:0] MODE_SWK = 3'h5;
	localparam logic [2:0] MODE_RX_SWK = 3'h6;
	localparam logic [2:0] MODE_NRM_SWK = 3'h7;
	localparam int MODE_SWK_BIT = 2;

	// device operating modes
	localparam logic [1:0] DEV_NORMAL = 2'h0;
	localparam logic [1:0] DEV_STOP = 2'h1;
	localparam logic [1:0] DEV_SLEEP = 2'h2;

	// ****************************************
	// counts and timing
	// ****************************************
	localparam logic [5:0] ERR_CNT_FULL = 6'h1f;
	localparam logic [5:0] ERR_CNT_OVF = 6'h20;
	localparam int CLK_MHZ = 250;
	localparam int SILENCE_US = 1000;
	localparam int SILENCE_CYC = SILENCE_US * CLK_MHZ;
	localparam logic [31:0] RESET_ZERO = 32'h0;

	// selective-wake detector states, gray along the usual path
	typedef enum logic [1:0] {
		SW_IDLE = 2'b00,
		SW_FRAME = 2'b01,
		SW_PAT1 = 2'b11,
		SW_PAT2 = 2'b10
	} sw_state_e;

endpackage : swk_mode_pkg

// ### design/can_selective_wake_mode_ctrl.sv
// selective-wake mode control, status flags and register slave
//
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module can_selective_wake_mode_ctrl
	import swk_mode_pkg::*;
#(
	parameter int SILENCE_CYCLES = SILENCE_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// avalon-mm slave
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// frame decoder events, same clock
	input wire logic bus_activity,
	input wire logic frame_ok,
	input wire logic protocol_error,
	input wire logic frame_valid_dec,
	input wire logic wake_pattern,
	input wire logic wake_frame,
	input wire logic rx_bus,
	// transceiver outputs
	output logic rxd_out,
	output logic tx_enable,
	output logic timeout_irq,
	output logic wake_irq,
	output logic [2:0] eff_mode,
	output logic eff_swk
);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic mode_has_swk(input logic [2:0] m);
		return m == MODE_SWK || m == MODE_RX_SWK || m == MODE_NRM_SWK;
	endfunction : mode_has_swk

	function automatic logic mode_receives(input logic [2:0] m);
		return m[1];
	endfunction : mode_receives

	logic [2:0] mode_reg;
	logic bus_timeout_irq_mask;
	logic config_valid_bit;
	logic [1:0] dev_mode_reg;
	logic bus_timeout_flag;
	logic bus_silence_flag;
	logic sync_flag;
	logic wake_armed_flag;
	logic system_error_bit;
	logic [5:0] protocol_error_count;
	logic [31:0] silence_cnt;
	logic silence_expired;
	logic woken_reg;
	sw_state_e sw_state, sw_next;
	logic wr_ctrl, wr_clr, rd_stb, ack_reg;
	logic clr_timeout, clr_system_error_bit;
	logic mode_write, swk_enable_evt;
	logic wake_evt, ovf_evt;
	logic swk_active;

	// ****************************************
	// bus slave, one wait state per access
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (read || write) && !ack_reg;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			waitrequest <= 1'b1;
		end else begin
			waitrequest <= !((read || write) && !ack_reg && waitrequest);
		end
	end

	assign wr_ctrl = write && !waitrequest && address == ADDR_CTRL;
	assign wr_clr = write && !waitrequest && address == ADDR_CLR;
	assign rd_stb = read && waitrequest;
	assign clr_timeout = wr_clr && writedata[ST_TIMEOUT];
	assign clr_system_error_bit = wr_clr && writedata[ST_SYSTEM_ERROR_BIT];
	assign mode_write = wr_ctrl && dev_mode_reg == DEV_NORMAL;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			readdata <= RESET_ZERO;
		end else if (rd_stb) begin
			readdata <= RESET_ZERO;
			case (address)
				ADDR_CTRL: begin
					readdata[CTRL_MODE_LSB +: 3] <= mode_reg;
					readdata[CTRL_MASK_BIT] <= bus_timeout_irq_mask;
					readdata[CTRL_CFG_BIT] <= config_valid_bit;
					readdata[CTRL_DEV_LSB +: 2] <= dev_mode_reg;
				end
				ADDR_STAT: begin
					readdata[ST_TIMEOUT] <= bus_timeout_flag;
					readdata[ST_SILENCE] <= bus_silence_flag;
					readdata[ST_SYNC] <= sync_flag;
					readdata[ST_ARMED] <= wake_armed_flag;
					readdata[ST_SYSTEM_ERROR_BIT] <= system_error_bit;
					readdata[ST_CNT_LSB +: 6] <= protocol_error_count;
				end
				ADDR_EFF: begin
					readdata[CTRL_MODE_LSB +: 3] <= eff_mode;
					readdata[MODE_SWK_BIT + 1] <= eff_swk;
				end
				default: begin
					readdata <= RESET_ZERO;
				end
			endcase
		end
	end

	// ****************************************
	// control register
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_reg <= MODE_OFF;
			bus_timeout_irq_mask <= 1'b0;
			config_valid_bit <= 1'b0;
			dev_mode_reg <= DEV_NORMAL;
		end else if (wr_ctrl) begin
			if (mode_write) begin
				mode_reg <= writedata[CTRL_MODE_LSB +: 3];
			end
			bus_timeout_irq_mask <= writedata[CTRL_MASK_BIT];
			config_valid_bit <= writedata[CTRL_CFG_BIT];
			dev_mode_reg <= writedata[CTRL_DEV_LSB +: 2];
		end
	end

	// ****************************************
	// effective mode; error drops eff_swk and the frame wake, pattern wake stays, code kept
	// ****************************************
	assign swk_active = mode_has_swk(mode_reg) && !system_error_bit;
	assign swk_enable_evt = mode_write && mode_has_swk(writedata[CTRL_MODE_LSB +: 3])
		&& !mode_has_swk(mode_reg);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			eff_mode <= MODE_OFF;
			eff_swk <= 1'b0;
		end else begin
			eff_mode <= mode_reg;
			eff_swk <= swk_active;
		end
	end

	// ****************************************
	// silence timer, shared by both flags
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			silence_cnt <= RESET_ZERO;
		end else if (bus_activity) begin
			silence_cnt <= RESET_ZERO;
		end else if (silence_cnt != 32'(SILENCE_CYCLES)) begin
			silence_cnt <= silence_cnt + 32'h1;
		end
	end
	// one-cycle event at the moment of expiry
	assign silence_expired = !bus_activity && silence_cnt == 32'(SILENCE_CYCLES - 1);

	// ****************************************
	// detector state
	// ****************************************
	assign ovf_evt = protocol_error && protocol_error_count == ERR_CNT_FULL && swk_active;
	assign wake_evt = ovf_evt || (sw_state == SW_PAT2 && wake_pattern)
		|| (sw_state == SW_FRAME && wake_frame && swk_active);

	always_comb begin
		sw_next = sw_state;
		case (sw_state)
			SW_IDLE: begin
				if (swk_active && !woken_reg) begin
					sw_next = SW_FRAME;
				end else if (mode_has_swk(mode_reg) && system_error_bit && !woken_reg) begin
					sw_next = SW_PAT2;
				end
			end
			SW_FRAME: begin
				if (wake_evt || !swk_active) begin
					sw_next = SW_IDLE;
				end else if (silence_expired) begin
					sw_next = SW_PAT1;
				end
			end
			SW_PAT1: begin
				if (!swk_active) begin
					sw_next = SW_IDLE;
				end else if (wake_pattern) begin
					sw_next = SW_FRAME;
				end
			end
			SW_PAT2: begin
				if (wake_evt || !mode_has_swk(mode_reg)) begin
					sw_next = SW_IDLE;
				end
			end
			default: begin
				sw_next = SW_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sw_state <= SW_IDLE;
		end else begin
			sw_state <= sw_next;
		end
	end

	// woken state freezes detection until the host rearms by any mode write, same code or new
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			woken_reg <= 1'b0;
		end else if (mode_write) begin
			woken_reg <= 1'b0;
		end else if (wake_evt) begin
			woken_reg <= 1'b1;
		end
	end

	// ****************************************
	// timeout flag and interrupt
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_timeout_flag <= 1'b0;
		end else if (silence_expired && (sw_state == SW_FRAME || sw_state == SW_PAT2)) begin
			bus_timeout_flag <= 1'b1;
		end else if (clr_timeout) begin
			bus_timeout_flag <= 1'b0;
		end
	end

	// pulse per event, independent of the flag; no wake path exists from here
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			timeout_irq <= 1'b0;
		end else begin
			timeout_irq <= silence_expired && bus_timeout_irq_mask
				&& (sw_state == SW_FRAME || sw_state == SW_PAT2)
				&& dev_mode_reg != DEV_SLEEP;
		end
	end

	// ****************************************
	// silence and sync flags
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_silence_flag <= 1'b0;
		end else if (silence_expired && (sw_state == SW_FRAME || sw_state == SW_PAT2)) begin
			bus_silence_flag <= 1'b1;
		end else if (wake_pattern) begin
			bus_silence_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync_flag <= 1'b0;
		end else if (protocol_error) begin
			sync_flag <= 1'b0;
		end else if (frame_ok && (mode_receives(mode_reg) || sw_state == SW_FRAME)) begin
			sync_flag <= 1'b1;
		end
	end

	// ****************************************
	// system error, armed flag, error counter
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			system_error_bit <= 1'b0;
		end else if (ovf_evt) begin
			system_error_bit <= 1'b1;
		end else if (swk_enable_evt) begin
			system_error_bit <= !config_valid_bit;
		end else if (clr_system_error_bit && config_valid_bit) begin
			system_error_bit <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wake_armed_flag <= 1'b0;
		end else if (wake_evt || !mode_reg[MODE_SWK_BIT]) begin
			wake_armed_flag <= 1'b0;
		end else if (!woken_reg
			&& (sw_state == SW_FRAME || sw_state == SW_PAT1 || sw_state == SW_PAT2)) begin
			wake_armed_flag <= 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			protocol_error_count <= 6'h0;
		end else if (!mode_receives(mode_reg) && !mode_has_swk(mode_reg)) begin
			protocol_error_count <= 6'h0;
		end else if (woken_reg) begin
			protocol_error_count <= protocol_error_count;
		end else if (ovf_evt) begin
			protocol_error_count <= ERR_CNT_OVF;
		end else if (protocol_error && protocol_error_count < ERR_CNT_FULL) begin
			protocol_error_count <= protocol_error_count + 6'h1;
		end else if (frame_valid_dec && protocol_error_count != 6'h0) begin
			protocol_error_count <= protocol_error_count - 6'h1;
		end
	end

	// ****************************************
	// transceiver paths
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rxd_out <= 1'b1;
			tx_enable <= 1'b0;
			wake_irq <= 1'b0;
		end else begin
			// rx follows the bus in receiving modes, else held high; never forced low by a frame wake
			rxd_out <= mode_receives(mode_reg) ? rx_bus : 1'b1;
			tx_enable <= mode_reg[0] && mode_reg[1];
			wake_irq <= wake_evt;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	sequence expire_s;
		silence_expired && (sw_state == SW_FRAME || sw_state == SW_PAT2);
	endsequence

	timeout_set_a: assert property (@(posedge clk) disable iff (rst)
		expire_s |=> bus_timeout_flag) else $error("timeout flag not set");
	timeout_hold_a: assert property (@(posedge clk) disable iff (rst)
		bus_timeout_flag && !clr_timeout |=> bus_timeout_flag)
		else $error("timeout flag dropped");
	timeout_irq_a: assert property (@(posedge clk) disable iff (rst)
		(expire_s and (bus_timeout_irq_mask && dev_mode_reg != DEV_SLEEP)) |=> timeout_irq)
		else $error("timeout irq missing");
	sleep_irq_a: assert property (@(posedge clk) disable iff (rst)
		dev_mode_reg == DEV_SLEEP && $stable(dev_mode_reg) |=> !timeout_irq)
		else $error("timeout irq in sleep");
	sync_clear_a: assert property (@(posedge clk) disable iff (rst)
		protocol_error |=> !sync_flag) else $error("sync not cleared");
	mode_lock_a: assert property (@(posedge clk) disable iff (rst)
		wr_ctrl && dev_mode_reg != DEV_NORMAL |=> $stable(mode_reg))
		else $error("mode changed outside normal");
	armed_clear_a: assert property (@(posedge clk) disable iff (rst)
		!mode_reg[MODE_SWK_BIT] |=> !wake_armed_flag) else $error("armed flag kept");
	ovf_count_a: assert property (@(posedge clk) disable iff (rst)
		ovf_evt && !woken_reg |=> protocol_error_count == ERR_CNT_OVF && system_error_bit)
		else $error("overflow not handled");
	eff_swk_a: assert property (@(posedge clk) disable iff (rst)
		system_error_bit && $stable(system_error_bit) |=> !eff_swk && eff_mode == $past(mode_reg))
		else $error("wake kept under error");

endmodule : can_selective_wake_mode_ctrl

// ### tb/swk_bus_model.sv
// far-side model: frame decoder event source and bus data line
`timescale 1ns/1ps
module swk_bus_model (
	// clock
	input wire logic clk,
	// decoder events and bus data
	output logic bus_activity,
	output logic frame_ok,
	output logic protocol_error,
	output logic frame_valid_dec,
	output logic wake_pattern,
	output logic wake_frame,
	output logic rx_bus
);
	initial begin
		{bus_activity, frame_ok, protocol_error, frame_valid_dec, wake_pattern, wake_frame} = 6'h00;
		rx_bus = 1'b1;
	end
	// recessive when idle, toggling while traffic is on the wire
	always @(posedge clk) rx_bus <= bus_activity ? ~rx_bus : 1'b1;
	// one event with activity; the bits of k are driven as given, so a good frame and an error can come together
	task ev(input logic [4:0] k);
		@(posedge clk);
		bus_activity <= 1'b1;
		{frame_ok, protocol_error, frame_valid_dec, wake_pattern, wake_frame} <= k;
		@(posedge clk);
		{frame_ok, protocol_error, frame_valid_dec, wake_pattern, wake_frame} <= 5'h00;
		bus_activity <= 1'b0;
	endtask : ev
endmodule : swk_bus_model

// ### tb/can_selective_wake_mode_ctrl_tb.sv
// testbench: register tasks and mode, flag and timeout scenarios
`timescale 1ns/1ps
module can_selective_wake_mode_ctrl_tb;
	import swk_mode_pkg::*;
	logic clk = 1'b0, rst, read, write;
	logic [3:0] address;
	logic [31:0] writedata, readdata, d;
	logic waitrequest, rxd_out, tx_enable, timeout_irq, wake_irq, eff_swk;
	logic bus_activity, frame_ok, protocol_error, frame_valid_dec, wake_pattern, wake_frame, rx_bus;
	logic [2:0] eff_mode;
	int bad_count = 0, tests_run = 0, to_cnt = 0, wk_cnt = 0, snap, c;
	always #2 clk = ~clk;
	always @(posedge clk) begin
		if (timeout_irq === 1'b1) to_cnt++;
		if (wake_irq === 1'b1) wk_cnt++;
	end
	can_selective_wake_mode_ctrl #(.SILENCE_CYCLES(20)) can_selective_wake_mode_ctrl_i (
		.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.bus_activity(bus_activity), .frame_ok(frame_ok), .protocol_error(protocol_error),
		.frame_valid_dec(frame_valid_dec), .wake_pattern(wake_pattern), .wake_frame(wake_frame),
		.rx_bus(rx_bus), .rxd_out(rxd_out), .tx_enable(tx_enable), .timeout_irq(timeout_irq),
		.wake_irq(wake_irq), .eff_mode(eff_mode), .eff_swk(eff_swk));
	swk_bus_model swk_bus_model_i (
		.clk(clk), .bus_activity(bus_activity), .frame_ok(frame_ok),
		.protocol_error(protocol_error), .frame_valid_dec(frame_valid_dec),
		.wake_pattern(wake_pattern), .wake_frame(wake_frame), .rx_bus(rx_bus));
	// ****************************************
	// tasks
	// ****************************************
	task results;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// one avalon transfer, held until waitrequest is seen low
	task xfer(input logic [3:0] a, input logic w, input logic [31:0] wd);
		int i;
		@(posedge clk);
		address <= a;
		writedata <= wd;
		write <= w;
		read <= ~w;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (waitrequest === 1'b0) break;
		end
		if (i == 20) begin
			bad_count++;
			results();
		end
		d = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask : xfer
	task wr(input logic [3:0] a, input logic [31:0] wd);
		xfer(a, 1'b1, wd);
	endtask : wr
	task rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		xfer(a, 1'b0, 32'h0);
		chk(d & m, e);
	endtask : rd
	// bounded wait for the n-th timeout interrupt
	task wait_to(input int n);
		int i;
		for (i = 0; i < 60 && to_cnt < n; i++) @(posedge clk);
		chk(to_cnt, n);
	endtask : wait_to
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		rst = 1'b1;
		{read, write, address, writedata} = 38'h0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd(ADDR_STAT, 32'hffffffff, 32'h0);
		rd(ADDR_CTRL, 32'hffffffff, 32'h0);
		rd(ADDR_EFF, 32'hffffffff, 32'h0);
		rd(4'h2, 32'hffffffff, 32'h0); // unmapped place reads zero
		$display("test reset done");
		for (c = 0; c < 8; c++) begin
			wr(ADDR_CTRL, 32'h20 | c);
			rd(ADDR_CTRL, 32'h7, c);
			rd(ADDR_EFF, 32'hf, ((c[2] & (c[1] | c[0])) << 3) | c);
			chk({eff_swk, eff_mode}, ((c[2] & (c[1] | c[0])) << 3) | c);
			chk(tx_enable, c[1] & c[0]);
		end
		$display("test modes done");
		swk_bus_model_i.ev(5'h10);
		@(posedge clk);
		@(negedge clk);
		chk(rxd_out, 1'b0);
		rd(ADDR_STAT, 32'h3f04, 32'h0004);
		swk_bus_model_i.ev(5'h08);
		rd(ADDR_STAT, 32'h3f04, 32'h0100);
		swk_bus_model_i.ev(5'h04);
		rd(ADDR_STAT, 32'h3f04, 32'h0);
		$display("test sync done");
		wr(ADDR_CTRL, 32'h21);
		rd(ADDR_STAT, 32'h18, 32'h0);
		wr(ADDR_CTRL, 32'h35);
		repeat (2) @(posedge clk);
		rd(ADDR_STAT, 32'h18, 32'h08);
		wait_to(1);
		rd(ADDR_STAT, 32'h3, 32'h3);
		swk_bus_model_i.ev(5'h02);
		rd(ADDR_STAT, 32'h3, 32'h1);
		wait_to(2);
		rd(ADDR_STAT, 32'h1, 32'h1);
		wr(ADDR_CLR, 32'h1);
		rd(ADDR_STAT, 32'h1, 32'h0);
		$display("test timeout done");
		wr(ADDR_CTRL, 32'h135);
		wr(ADDR_CTRL, 32'h133);
		rd(ADDR_CTRL, 32'h307, 32'h105);
		rd(ADDR_EFF, 32'hf, 32'hd);
		rd(ADDR_STAT, 32'h2, 32'h2);
		wr(ADDR_CTRL, 32'h35);
		wr(ADDR_CTRL, 32'h37);
		for (c = 0; c < 32; c++) swk_bus_model_i.ev(5'h08);
		rd(ADDR_STAT, 32'h3f18, 32'h2010);
		rd(ADDR_EFF, 32'hf, 32'h7);
		rd(ADDR_CTRL, 32'h7, 32'h7);
		snap = wk_cnt;
		swk_bus_model_i.ev(5'h01);
		repeat (4) @(posedge clk);
		chk(wk_cnt, snap);
		$display("test overflow done");
		wr(ADDR_CLR, 32'h10);
		wr(ADDR_CTRL, 32'h23);
		wr(ADDR_CTRL, 32'h37);
		rd(ADDR_STAT, 32'h10, 32'h0);
		snap = wk_cnt;
		swk_bus_model_i.ev(5'h01);
		repeat (4) @(posedge clk);
		chk(wk_cnt, snap + 1);
		wr(ADDR_CTRL, 32'h23);
		wr(ADDR_CTRL, 32'h235);
		snap = wk_cnt;
		repeat (60) @(posedge clk);
		chk(wk_cnt, snap);
		chk(to_cnt, 2);
		$display("test wake done");
		results();
	end
	// whole-run guard against a hang
	initial begin
		#200000;
		bad_count++;
		results();
	end
endmodule : can_selective_wake_mode_ctrl_tb
